// ===== iep_pkg.sv
// Constants of the interrupt flag, enable and priority block
// Function
// [R1] Pin B flag sets on its event
// [R2] Pin B flag holds until software clears
// [R3] Pin A flag sets and holds until cleared
// [R4] Unimplemented bits read zero, ignore writes
// [R5] Flags set regardless of any enable
// [R6] Flags readable for polling while disabled
// [R7] Software clears flag before enable, after service
// [R8] Peripheral flags split over two registers
// [R9] Two enable registers; group gate when flat
// [R10] Priority bits act only with scheme on
// [R11] Scheme enable bit 7, resets to zero
// [R12] Priority bit one high, zero low
// [R13] Pin enable one allows, zero blocks
// [R14] Request when flag, enable and gates allow
// [R15] Event beats a same-cycle software clear
package iep_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PA_W   = 8;   // Peripheral group A sources
  localparam int unsigned PB_W   = 4;   // Peripheral group B sources

  // Register byte offsets
  localparam logic [7:0] OFS_MAIN_CTRL  = 8'h00;
  localparam logic [7:0] OFS_PIN_LEVEL  = 8'h04;
  localparam logic [7:0] OFS_FLAGS_A    = 8'h08;
  localparam logic [7:0] OFS_FLAGS_B    = 8'h0C;
  localparam logic [7:0] OFS_ENABLES_A  = 8'h10;
  localparam logic [7:0] OFS_ENABLES_B  = 8'h14;
  localparam logic [7:0] OFS_LEVELS_A   = 8'h18;
  localparam logic [7:0] OFS_LEVELS_B   = 8'h1C;
  localparam logic [7:0] OFS_RESET_CTRL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;

  // Field positions in main_irq_control
  localparam int unsigned BIT_GLOBAL_GATE = 7;
  localparam int unsigned BIT_GROUP_GATE  = 6;
  localparam int unsigned BIT_PIN_B_EN    = 4;
  localparam int unsigned BIT_PIN_A_EN    = 3;
  localparam int unsigned BIT_PIN_B_FLAG  = 1;
  localparam int unsigned BIT_PIN_A_FLAG  = 0;

  // Field positions in the pin level register
  localparam int unsigned BIT_PIN_B_LEVEL = 7;
  localparam int unsigned BIT_PIN_A_LEVEL = 6;

  // Field position in reset_control_reg
  localparam int unsigned BIT_PRIO_ON = 7;

  // Field positions in the request status register
  localparam int unsigned BIT_REQ_HIGH = 1;
  localparam int unsigned BIT_REQ_LOW  = 0;

  // Reset values
  localparam logic [7:0]      RST_CTRL  = 8'h00;
  localparam logic [PA_W-1:0] RST_GRP_A = 8'h00;
  localparam logic [PB_W-1:0] RST_GRP_B = 4'h0;
  localparam logic            RST_BIT   = 1'b0;

endpackage : iep_pkg

// ===== iep_sync.sv
// Two flip-flop synchroniser bank for asynchronous pin inputs
module iep_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;  // First stage, read only by the second

  // Two stages; the first may go metastable, the second settles it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : iep_sync

// ===== iep_flag_bank.sv
// Bank of sticky event flags with software write and set priority
module iep_flag_bank #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set_evt,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] flags_q
);

  // Software may write either value; a same-cycle event still sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else if (wr_en) begin
      flags_q <= wr_data | set_evt;  // R15 R5
    end else begin
      flags_q <= flags_q | set_evt;  // R2 R5
    end
  end

endmodule : iep_flag_bank

// ===== iep_top.sv
// Interrupt flag, enable and priority block with APB register access
module iep_top
  import iep_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [iep_pkg::ADDR_W-1:0] paddr,
  input  wire logic [iep_pkg::DATA_W-1:0] pwdata,
  output logic      [iep_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // External interrupt pins, asynchronous
  input  wire logic                       pin_a_irq,
  input  wire logic                       pin_b_irq,
  // Peripheral event pulses, same clock
  input  wire logic [iep_pkg::PA_W-1:0]   periph_event_a,
  input  wire logic [iep_pkg::PB_W-1:0]   periph_event_b,
  // Requests to the core
  output logic                            irq_high,
  output logic                            irq_low
);
  import iep_pkg::*;

  // Synchronised pins and their previous values
  logic [1:0]      pins_sync;      // [1] pin B, [0] pin A
  logic [1:0]      pins_prev_q;    // Edge detector history
  logic            pin_a_rise;     // Pin A interrupt condition
  logic            pin_b_rise;     // Pin B interrupt condition

  // Control and configuration state
  logic            global_irq_gate_q;        // Global gate
  logic            peripheral_group_gate_q;  // Group gate, low gate when prioritised
  logic            pin_a_event_enable_q;     // Pin A enable
  logic            pin_b_event_enable_q;     // Pin B enable
  logic            pin_a_event_level_q;      // Pin A priority
  logic            pin_b_event_level_q;      // Pin B priority
  logic            priority_scheme_on_q;     // Priority scheme on
  logic [PA_W-1:0] periph_enables_a_q;       // Group A enables
  logic [PB_W-1:0] periph_enables_b_q;       // Group B enables
  logic [PA_W-1:0] periph_levels_a_q;        // Group A priorities
  logic [PB_W-1:0] periph_levels_b_q;        // Group B priorities

  // Flags
  logic [1:0]      pin_flags;      // [1] pin_b_event_flag, [0] pin_a_event_flag
  logic            pin_a_event_flag;
  logic            pin_b_event_flag;
  logic [PA_W-1:0] periph_flags_a;
  logic [PB_W-1:0] periph_flags_b;

  // Bus decode
  logic            wr_stb;         // Write takes effect this edge
  logic            wr_main;
  logic            wr_flags_a;
  logic            wr_flags_b;
  logic            addr_hit;       // Address maps to a register
  logic [7:0]      rd_byte;        // Read value before widening

  // Request terms
  logic            pin_a_act;      // Pin A flag and enable
  logic            pin_b_act;
  logic [PA_W-1:0] pa_act;         // Peripheral flag and enable
  logic [PB_W-1:0] pb_act;
  logic            any_pin;
  logic            any_periph;
  logic            hi_src;         // Active source at high level
  logic            lo_src;         // Active source at low level
  logic            irq_high_d;
  logic            irq_low_d;

  // Pins cross into the clock domain before anything reads them
  iep_sync #(
    .W (2)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pin_b_irq, pin_a_irq}),
    .sync_out (pins_sync)
  );

  // Rising-edge history of the synchronised pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_q <= 2'h0;
    end else begin
      pins_prev_q <= pins_sync;
    end
  end

  // A rising edge is the interrupt condition of each pin
  assign pin_a_rise = pins_sync[0] & ~pins_prev_q[0];
  assign pin_b_rise = pins_sync[1] & ~pins_prev_q[1];

  // APB: zero wait states, every access completes in its access phase
  assign pready  = 1'b1;
  assign wr_stb  = psel & penable & pwrite;

  // Address decode over the mapped word offsets
  always_comb begin
    case (paddr)
      OFS_MAIN_CTRL, OFS_PIN_LEVEL, OFS_FLAGS_A, OFS_FLAGS_B,
      OFS_ENABLES_A, OFS_ENABLES_B, OFS_LEVELS_A, OFS_LEVELS_B,
      OFS_RESET_CTRL, OFS_IRQ_STATUS: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error in the access phase
  assign pslverr = psel & penable & ~addr_hit;

  assign wr_main    = wr_stb & (paddr == OFS_MAIN_CTRL);
  assign wr_flags_a = wr_stb & (paddr == OFS_FLAGS_A);
  assign wr_flags_b = wr_stb & (paddr == OFS_FLAGS_B);

  // Pin flags share the main control word with the gates
  iep_flag_bank #(
    .W (2)
  ) u_pin_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt ({pin_b_rise, pin_a_rise}),  // R1 R3 R5
    .wr_en   (wr_main),
    .wr_data ({pwdata[BIT_PIN_B_FLAG], pwdata[BIT_PIN_A_FLAG]}),
    .flags_q (pin_flags)
  );

  assign pin_a_event_flag = pin_flags[0];
  assign pin_b_event_flag = pin_flags[1];

  // Group A flags, the first of two flag registers
  iep_flag_bank #(
    .W (PA_W)
  ) u_flags_a (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (periph_event_a),  // R8 R5
    .wr_en   (wr_flags_a),
    .wr_data (pwdata[PA_W-1:0]),
    .flags_q (periph_flags_a)
  );

  // Group B flags; the upper bits of this word do not exist
  iep_flag_bank #(
    .W (PB_W)
  ) u_flags_b (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (periph_event_b),  // R8 R5
    .wr_en   (wr_flags_b),
    .wr_data (pwdata[PB_W-1:0]),
    .flags_q (periph_flags_b)
  );

  // Gates and pin enables in the main control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_gate_q       <= RST_BIT;
      peripheral_group_gate_q <= RST_BIT;
      pin_a_event_enable_q    <= RST_BIT;
      pin_b_event_enable_q    <= RST_BIT;
    end else if (wr_main) begin
      // Only implemented positions are stored
      global_irq_gate_q       <= pwdata[BIT_GLOBAL_GATE];
      peripheral_group_gate_q <= pwdata[BIT_GROUP_GATE];
      pin_a_event_enable_q    <= pwdata[BIT_PIN_A_EN];  // R13
      pin_b_event_enable_q    <= pwdata[BIT_PIN_B_EN];  // R13
    end
  end

  // Pin priority levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_event_level_q <= RST_BIT;
      pin_b_event_level_q <= RST_BIT;
    end else if (wr_stb && paddr == OFS_PIN_LEVEL) begin
      pin_a_event_level_q <= pwdata[BIT_PIN_A_LEVEL];  // R12
      pin_b_event_level_q <= pwdata[BIT_PIN_B_LEVEL];  // R12
    end
  end

  // Peripheral enables, two registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_enables_a_q <= RST_GRP_A;
      periph_enables_b_q <= RST_GRP_B;
    end else begin
      if (wr_stb && paddr == OFS_ENABLES_A) begin
        periph_enables_a_q <= pwdata[PA_W-1:0];  // R9
      end
      if (wr_stb && paddr == OFS_ENABLES_B) begin
        periph_enables_b_q <= pwdata[PB_W-1:0];  // R9 R4
      end
    end
  end

  // Peripheral priority levels, two registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_levels_a_q <= RST_GRP_A;
      periph_levels_b_q <= RST_GRP_B;
    end else begin
      if (wr_stb && paddr == OFS_LEVELS_A) begin
        periph_levels_a_q <= pwdata[PA_W-1:0];  // R10
      end
      if (wr_stb && paddr == OFS_LEVELS_B) begin
        periph_levels_b_q <= pwdata[PB_W-1:0];  // R10 R4
      end
    end
  end

  // Priority scheme switch; the reset status bits live elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_scheme_on_q <= RST_BIT;  // R11
    end else if (wr_stb && paddr == OFS_RESET_CTRL) begin
      priority_scheme_on_q <= pwdata[BIT_PRIO_ON];  // R11
    end
  end

  // Read mux; absent bits are left at zero
  always_comb begin
    rd_byte = RST_CTRL;
    case (paddr)
      OFS_MAIN_CTRL: begin
        rd_byte[BIT_GLOBAL_GATE] = global_irq_gate_q;
        rd_byte[BIT_GROUP_GATE]  = peripheral_group_gate_q;
        rd_byte[BIT_PIN_B_EN]    = pin_b_event_enable_q;
        rd_byte[BIT_PIN_A_EN]    = pin_a_event_enable_q;
        rd_byte[BIT_PIN_B_FLAG]  = pin_b_event_flag;  // R6
        rd_byte[BIT_PIN_A_FLAG]  = pin_a_event_flag;  // R6
      end
      OFS_PIN_LEVEL: begin
        rd_byte[BIT_PIN_B_LEVEL] = pin_b_event_level_q;
        rd_byte[BIT_PIN_A_LEVEL] = pin_a_event_level_q;
      end
      OFS_FLAGS_A: begin
        rd_byte[PA_W-1:0] = periph_flags_a;  // R6
      end
      OFS_FLAGS_B: begin
        rd_byte[PB_W-1:0] = periph_flags_b;  // R6 R4
      end
      OFS_ENABLES_A: begin
        rd_byte[PA_W-1:0] = periph_enables_a_q;
      end
      OFS_ENABLES_B: begin
        rd_byte[PB_W-1:0] = periph_enables_b_q;  // R4
      end
      OFS_LEVELS_A: begin
        rd_byte[PA_W-1:0] = periph_levels_a_q;
      end
      OFS_LEVELS_B: begin
        rd_byte[PB_W-1:0] = periph_levels_b_q;  // R4
      end
      OFS_RESET_CTRL: begin
        rd_byte[BIT_PRIO_ON] = priority_scheme_on_q;
      end
      OFS_IRQ_STATUS: begin
        rd_byte[BIT_REQ_HIGH] = irq_high;
        rd_byte[BIT_REQ_LOW]  = irq_low;
      end
      default: begin
        rd_byte = RST_CTRL;
      end
    endcase
  end

  // Read data is registered in the setup phase, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};  // R4
    end
  end

  // Source activity: flag and its own enable
  assign pin_a_act  = pin_a_event_flag & pin_a_event_enable_q;  // R13
  assign pin_b_act  = pin_b_event_flag & pin_b_event_enable_q;  // R13
  assign pa_act     = periph_flags_a & periph_enables_a_q;
  assign pb_act     = periph_flags_b & periph_enables_b_q;
  assign any_pin    = pin_a_act | pin_b_act;
  assign any_periph = (|pa_act) | (|pb_act);

  // Sort active sources by level; levels only count with the scheme on
  assign hi_src = (pin_a_act & pin_a_event_level_q) |
                  (pin_b_act & pin_b_event_level_q) |
                  (|(pa_act & periph_levels_a_q)) |
                  (|(pb_act & periph_levels_b_q));  // R10 R12
  assign lo_src = (pin_a_act & ~pin_a_event_level_q) |
                  (pin_b_act & ~pin_b_event_level_q) |
                  (|(pa_act & ~periph_levels_a_q)) |
                  (|(pb_act & ~periph_levels_b_q));  // R12

  // Request routing: flat mode uses one line, prioritised mode two
  always_comb begin
    if (priority_scheme_on_q) begin
      // Global gate opens high level; group gate also needed for low
      irq_high_d = global_irq_gate_q & hi_src;  // R14 R10
      irq_low_d  = global_irq_gate_q & peripheral_group_gate_q & lo_src;  // R14
    end else begin
      // Peripherals also need the group gate in flat mode
      irq_high_d = global_irq_gate_q &
                   (any_pin | (peripheral_group_gate_q & any_periph));  // R9 R14
      irq_low_d  = 1'b0;
    end
  end

  // Requests leave from flip-flops, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_high <= 1'b0;
      irq_low  <= 1'b0;
    end else begin
      irq_high <= irq_high_d;  // R14
      irq_low  <= irq_low_d;   // R14
    end
  end

endmodule : iep_top

// ===== iep_src_model.sv
// Model of the peripheral sources and external pins that feed the block
module iep_src_model
  import iep_pkg::*;
(
  input  wire logic             pclk,
  output logic                  pin_a_irq,
  output logic                  pin_b_irq,
  output logic [PA_W-1:0]       periph_event_a,
  output logic [PB_W-1:0]       periph_event_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // Sources idle low from time zero
  initial begin
    pin_a_irq      = 1'b0;
    pin_b_irq      = 1'b0;
    periph_event_a = '0;
    periph_event_b = '0;
  end

  // One-cycle peripheral event pulse, as a peripheral raises it
  task automatic pulse_periph(input logic [PA_W-1:0] a, input logic [PB_W-1:0] b);
    @(posedge pclk);
    periph_event_a <= a;
    periph_event_b <= b;
    @(posedge pclk);
    periph_event_a <= '0;
    periph_event_b <= '0;
  endtask : pulse_periph

  // Pin rise held past the synchroniser, then low long enough to re-arm
  task automatic raise_pins(input logic a, input logic b);
    @(posedge pclk);
    pin_a_irq <= a;
    pin_b_irq <= b;
    repeat (4) @(posedge pclk);
    pin_a_irq <= 1'b0;
    pin_b_irq <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : raise_pins
endmodule : iep_src_model

// ===== iep_chk_sva.sv
// Port checker of the interrupt flag, enable and priority block
module iep_chk
  import iep_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              pin_a_irq,
  input wire logic              pin_b_irq,
  input wire logic [PA_W-1:0]   periph_event_a,
  input wire logic [PB_W-1:0]   periph_event_b,
  input wire logic              irq_high,
  input wire logic              irq_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_q; // Shadow of main control
  logic       prio_q; // Shadow of scheme enable
  logic       ena0_q; // Shadow of group A enable bit 0
  logic       acc;    // APB access phase

  assign acc = psel && penable;

  // Shadows follow software writes at the access edge, as the block does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      prio_q <= 1'b0;
      ena0_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == OFS_MAIN_CTRL) ctrl_q <= pwdata[7:0];
      if (paddr == OFS_RESET_CTRL) prio_q <= pwdata[BIT_PRIO_ON];
      if (paddr == OFS_ENABLES_A) ena0_q <= pwdata[0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_unmapped_err: assert property (acc && paddr > OFS_IRQ_STATUS |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= OFS_IRQ_STATUS && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_low_flat: assert property (!$past(prio_q) |-> !irq_low)
    else $error("low request while scheme off");
  a_flat_group: assert property (!$past(prio_q) && ($past(ctrl_q) & 8'h58) == 8'h00 |-> !irq_high)
    else $error("request without any enable");
  a_gate_off: assert property (acc && pwrite && paddr == OFS_MAIN_CTRL && !pwdata[7]
                               |-> ##2 (!irq_high && !irq_low))
    else $error("request with global gate off");
  a_status_read: assert property (acc && !pwrite && paddr == OFS_IRQ_STATUS
                                  |-> prdata[1:0] == {$past(irq_high), $past(irq_low)})
    else $error("status read mismatch");
  a_periph_req: assert property (periph_event_a[0] && !psel && ctrl_q[7] && ctrl_q[6] && ena0_q && !prio_q
                                 |-> ##2 irq_high)
    else $error("enabled event gave no request");
endmodule : iep_chk

bind iep_top iep_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .pin_a_irq, .pin_b_irq, .periph_event_a, .periph_event_b, .irq_high, .irq_low);

// ===== test_interrupt_flag_enable_priority.sv
// Self-checking bench of the interrupt flag, enable and priority block
module test_interrupt_flag_enable_priority;
  timeunit 1ns;
  timeprecision 1ns;
  import iep_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite; // Clock, reset, bus control
  logic [7:0]      paddr;                                // Byte address
  logic [31:0]     pwdata, prdata, rd;                   // Bus data, last read
  logic            pready, pslverr, err;                 // Bus answer, last error
  logic            pin_a_irq, pin_b_irq, irq_high, irq_low;
  logic [PA_W-1:0] periph_event_a;
  logic [PB_W-1:0] periph_event_b;
  int              errors, compares, cycles;
  // Readable bits of each register, offsets 0x00 to 0x20
  localparam logic [7:0] MSK [9] = '{8'hDB, 8'hC0, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h80};

  iep_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_a_irq, .pin_b_irq, .periph_event_a, .periph_event_b, .irq_high, .irq_low);
  iep_src_model src_u (.pclk, .pin_a_irq, .pin_b_irq, .periph_event_a, .periph_event_b);

  // Free-running 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out;
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  // Compares {irq_high, irq_low}
  task automatic chk_irq(input logic [1:0] exp);
    compares++;
    if ({irq_high, irq_low} !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, {irq_high, irq_low}, exp);
    end
  endtask : chk_irq

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, {24'h00_0000, exp});
  endtask : rchk

  // Reset values, then a refused access to an unmapped word
  task automatic t_reset;
    for (int i = 0; i < 10; i++) rchk(8'(i * 4), 8'h00);
    apb(1'b0, 8'h28, 32'hFFFF_FFFF);
    chk_reg(rd, 32'h0000_0000);
    chk_reg({31'h0, err}, 32'h0000_0001);
  endtask : t_reset

  // All ones written everywhere, only implemented bits read back
  task automatic t_unimpl;
    for (int i = 0; i < 9; i++) wreg(8'(i * 4), 8'hFF);
    wreg(OFS_IRQ_STATUS, 8'hFF);
    for (int i = 0; i < 9; i++) rchk(8'(i * 4), MSK[i]);
    rchk(OFS_IRQ_STATUS, 8'h02);
    for (int i = 0; i < 9; i++) wreg(8'(i * 4), 8'h00);
    for (int i = 0; i < 10; i++) rchk(8'(i * 4), 8'h00);
  endtask : t_unimpl

  // Flags latch and stay while everything is disabled
  task automatic t_poll;
    src_u.pulse_periph(8'hA5, 4'h9);
    src_u.raise_pins(1'b1, 1'b1);
    rchk(OFS_FLAGS_A, 8'hA5);
    rchk(OFS_FLAGS_B, 8'h09);
    rchk(OFS_MAIN_CTRL, 8'h03);
    chk_irq(2'b00);
    repeat (20) @(posedge pclk);
    rchk(OFS_MAIN_CTRL, 8'h03);
    wreg(OFS_MAIN_CTRL, 8'h00);
    rchk(OFS_MAIN_CTRL, 8'h00);
    src_u.raise_pins(1'b0, 1'b1);
    rchk(OFS_MAIN_CTRL, 8'h02);
    wreg(OFS_MAIN_CTRL, 8'h00);
    wreg(OFS_FLAGS_A, 8'h00);
    wreg(OFS_FLAGS_B, 8'h00);
  endtask : t_poll

  // Single-level gating by group gate and pin A enable
  task automatic t_flat;
    wreg(OFS_ENABLES_A, 8'h01);
    wreg(OFS_MAIN_CTRL, 8'h80);
    src_u.pulse_periph(8'h01, 4'h0);
    repeat (3) @(posedge pclk);
    chk_irq(2'b00);
    wreg(OFS_MAIN_CTRL, 8'hC0);
    repeat (2) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_FLAGS_A, 8'h00);
    repeat (2) @(posedge pclk);
    chk_irq(2'b00);
    src_u.pulse_periph(8'h01, 4'h0);
    repeat (3) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_FLAGS_A, 8'h00);
    wreg(OFS_MAIN_CTRL, 8'h88);
    src_u.raise_pins(1'b1, 1'b0);
    chk_irq(2'b10);
    wreg(OFS_MAIN_CTRL, 8'h80);
    src_u.raise_pins(1'b1, 1'b0);
    chk_irq(2'b00);
    rchk(OFS_MAIN_CTRL, 8'h81);
    wreg(OFS_MAIN_CTRL, 8'h00);
  endtask : t_flat

  // Priority levels route to the two request lines only with the scheme on
  task automatic t_prio;
    wreg(OFS_RESET_CTRL, 8'h80);
    wreg(OFS_ENABLES_A, 8'h03);
    wreg(OFS_LEVELS_A, 8'h01);
    wreg(OFS_MAIN_CTRL, 8'hC0);
    src_u.pulse_periph(8'h01, 4'h0);
    repeat (3) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_FLAGS_A, 8'h00);
    src_u.pulse_periph(8'h02, 4'h0);
    repeat (3) @(posedge pclk);
    chk_irq(2'b01);
    wreg(OFS_RESET_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_FLAGS_A, 8'h00);
    wreg(OFS_LEVELS_A, 8'h00);
    wreg(OFS_MAIN_CTRL, 8'h00);
  endtask : t_prio

  // Group B and pin B route by their own level bits; group gate is the low gate
  task automatic t_prio_b;
    wreg(OFS_RESET_CTRL, 8'h80);
    wreg(OFS_ENABLES_B, 8'h04);
    wreg(OFS_LEVELS_B, 8'h04);
    wreg(OFS_MAIN_CTRL, 8'h90);
    src_u.pulse_periph(8'h00, 4'h4);
    repeat (3) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_FLAGS_B, 8'h00);
    src_u.raise_pins(1'b0, 1'b1);
    chk_irq(2'b00);
    wreg(OFS_MAIN_CTRL, 8'hD2);
    repeat (2) @(posedge pclk);
    chk_irq(2'b01);
    wreg(OFS_PIN_LEVEL, 8'h80);
    repeat (2) @(posedge pclk);
    chk_irq(2'b10);
    wreg(OFS_MAIN_CTRL, 8'h00);
    wreg(OFS_ENABLES_B, 8'h00);
    wreg(OFS_LEVELS_B, 8'h00);
    wreg(OFS_PIN_LEVEL, 8'h00);
    wreg(OFS_RESET_CTRL, 8'h00);
  endtask : t_prio_b

  // Event arriving at the very edge of a clearing write survives it
  task automatic t_race;
    fork
      wreg(OFS_FLAGS_A, 8'h00);
      begin
        @(posedge pclk);
        src_u.pulse_periph(8'h10, 4'h0);
      end
    join
    rchk(OFS_FLAGS_A, 8'h10);
    wreg(OFS_FLAGS_A, 8'h00);
  endtask : t_race

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_unimpl();
    t_poll();
    t_flat();
    t_prio();
    t_prio_b();
    t_race();
    close_out();
  end
endmodule : test_interrupt_flag_enable_priority
